/* File: rtl/prb_defs.vh */
/*
  Constants for the 8-bit port block: register offsets, reset values,
  field widths and the timer tick divider.
  Assumes a byte-wide CPU peripheral bus with one-cycle read and write strobes.
*/
// Function
// (R1) CPU bit ops read, modify, rewrite byte
// (R2) shared timer address: read counter, write load
// (R3) input pin bits read live pin level
// (R4) output pin bits read latch value
// (R5) latch bit n drives pin n
// (R6) read-modify-write copies pin levels into latch
// (R7) unmapped writes are discarded
// (R8) unmapped reads return undefined data
// (R9) software keeps a shadow byte copy
// (R10) direction bit 1 output, 0 input
// (R11) direction register reads all ones
// (R12) data writes update every latch bit
`ifndef PRB_DEFS_VH
`define PRB_DEFS_VH

`define PRB_ADDR_W        8
`define PRB_DATA_W        8
`define PRB_OFS_DATA      8'h00
`define PRB_OFS_DIR       8'h01
`define PRB_OFS_TIMER     8'h02
`define PRB_RST_DATA      8'h00
`define PRB_RST_DIR       8'h00
`define PRB_RST_LOAD      8'h00
`define PRB_RST_COUNT     8'h00
`define PRB_DIR_READBACK  8'hFF
`define PRB_UNMAPPED_READ 8'h00
`define PRB_TICK_DIV      16'h0004
`define PRB_TICK_W        16
`define PRB_TICK_ONE      16'h0001
`define PRB_COUNT_ONE     8'h01

`endif

/* File: rtl/prb_port.v */
/*
  8-bit general-purpose port with write-only direction register and a
  reloadable 8-bit up-counter sharing one address with its load register.
  Register bus: one-cycle read and write strobes, read data one cycle later.
  Assumes the CPU issues at most one of rd/wr per cycle; pins are
  synchronous to core_clk; pin drivers are resolved outside from pin_oe.
  Bit operations are done by the CPU as byte read then byte write; this
  block sees only plain byte accesses and keeps no memory of a pending op.
*/
`timescale 1ns/10ps
`include "prb_defs.vh"

module prb_port #(
  parameter [`PRB_TICK_W-1:0] TICK_DIV = `PRB_TICK_DIV
) (
  input  wire                    core_clk,
  input  wire                    rstn,
  input  wire [`PRB_ADDR_W-1:0]  bus_addr,
  input  wire                    bus_rd,
  input  wire                    bus_wr,
  input  wire [`PRB_DATA_W-1:0]  bus_wdata,
  output reg  [`PRB_DATA_W-1:0]  bus_rdata,
  output reg                     bus_rvalid,
  input  wire [`PRB_DATA_W-1:0]  pin_in,
  output wire [`PRB_DATA_W-1:0]  pin_out,
  output wire [`PRB_DATA_W-1:0]  pin_oe,
  output reg                     timer_ovf
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [`PRB_DATA_W-1:0] data_q;
  reg  [`PRB_DATA_W-1:0] data_d;
  reg  [`PRB_DATA_W-1:0] dir_q;
  reg  [`PRB_DATA_W-1:0] dir_d;
  reg  [`PRB_DATA_W-1:0] load_q;
  reg  [`PRB_DATA_W-1:0] load_d;
  reg  [`PRB_DATA_W-1:0] count_q;
  reg  [`PRB_DATA_W-1:0] count_d;
  reg                    ovf_d;
  reg  [`PRB_TICK_W-1:0] tick_q;
  reg  [`PRB_TICK_W-1:0] tick_d;
  reg  [`PRB_DATA_W-1:0] rdata_d;
  wire [`PRB_DATA_W-1:0] port_rd;
  wire [`PRB_TICK_W-1:0] tick_last;
  wire                   sel_data;
  wire                   sel_dir;
  wire                   sel_timer;
  wire                   wr_data;
  wire                   wr_dir;
  wire                   wr_load;
  wire                   tick;
  wire                   count_full;
  genvar                 g;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // one comparator shape for every register offset
  function prb_hit;
    input [`PRB_ADDR_W-1:0] addr;
    input [`PRB_ADDR_W-1:0] ofs;
    begin
      prb_hit = (addr == ofs);
    end
  endfunction

  assign sel_data  = prb_hit(bus_addr, `PRB_OFS_DATA);
  assign sel_dir   = prb_hit(bus_addr, `PRB_OFS_DIR);
  assign sel_timer = prb_hit(bus_addr, `PRB_OFS_TIMER);

  assign wr_data   = bus_wr & sel_data;
  assign wr_dir    = bus_wr & sel_dir;
  assign wr_load   = bus_wr & sel_timer;
  // any other address: no write enable, data dropped [R7]

  ////////////////////////////////////////////////////////////////////////
  // port data latch

  assign pin_out = data_q;  // [R5]

  // whole byte stored, input bits too, so a later output switch shows it;
  // a byte read back from input pins lands here as well
  always @* begin
    data_d = data_q;
    if (wr_data) begin
      data_d = bus_wdata;  // [R12] [R6]
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_q <= `PRB_RST_DATA;
    end else begin
      data_q <= data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port direction select

  assign pin_oe = dir_q;  // [R10]

  // write-only: a bit op here rewrites every bit from the all-ones read
  always @* begin
    dir_d = dir_q;
    if (wr_dir) begin
      dir_d = bus_wdata;  // [R10]
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= `PRB_RST_DIR;
    end else begin
      dir_q <= dir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timer tick divider

  assign tick_last = TICK_DIV - `PRB_TICK_ONE;
  assign tick      = (tick_q == tick_last);

  always @* begin
    if (tick) begin
      tick_d = {`PRB_TICK_W{1'h0}};
    end else begin
      tick_d = tick_q + `PRB_TICK_ONE;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_q <= {`PRB_TICK_W{1'h0}};
    end else begin
      tick_q <= tick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reloadable timer: load and counter share one address

  // a write reaches only the load register, the counter keeps running
  always @* begin
    load_d = load_q;
    if (wr_load) begin
      load_d = bus_wdata;  // [R2]
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      load_q <= `PRB_RST_LOAD;
    end else begin
      load_q <= load_d;
    end
  end

  assign count_full = &count_q;

  always @* begin
    count_d = count_q;
    ovf_d   = 1'h0;
    if (tick) begin
      if (count_full) begin
        count_d = load_q;
        ovf_d   = 1'h1;
      end else begin
        count_d = count_q + `PRB_COUNT_ONE;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= `PRB_RST_COUNT;
    end else begin
      count_q <= count_d;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timer_ovf <= 1'h0;
    end else begin
      timer_ovf <= ovf_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin read value

  // outputs show the latch, inputs show the live pin
  generate
    for (g = 0; g < `PRB_DATA_W; g = g + 1) begin : g_port_rd
      assign port_rd[g] = dir_q[g] ? data_q[g] : pin_in[g];  // [R3] [R4]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux

  // unmapped reads give a fixed value; software must not rely on it
  always @* begin
    rdata_d = `PRB_UNMAPPED_READ;  // [R8]
    if (sel_data) begin
      rdata_d = port_rd;  // [R3] [R4]
    end else if (sel_dir) begin
      rdata_d = `PRB_DIR_READBACK;  // [R11]
    end else if (sel_timer) begin
      rdata_d = count_q;  // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data register

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rvalid <= 1'h0;
    end else begin
      bus_rvalid <= bus_rd;
    end
  end

  // held until the next read, so a slow master may take it late
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= {`PRB_DATA_W{1'h0}};
    end else if (bus_rd) begin
      bus_rdata <= rdata_d;
    end
  end

endmodule // prb_port

/* File: dv/prb_port_assertions.sv */
/* prb_port checker; assumes bind by name */
`timescale 1ns/10ps
module prb_chk(input wire core_clk,rstn,bus_rd,bus_wr,bus_rvalid,timer_ovf,
 input wire [7:0] bus_addr,bus_wdata,bus_rdata,pin_in,pin_out,pin_oe);
default clocking @(posedge core_clk); endclocking
default disable iff (!rstn);
chk_rd_valid: assert property (bus_rd|=>bus_rvalid) else $error("rv");
chk_dir_ones: assert property (bus_rd&&bus_addr==8'h01|=>bus_rdata==8'hFF) else $error("dir");
chk_data_mix: assert property (bus_rd&&bus_addr==8'h00|=>
 bus_rdata==($past(pin_oe)&$past(pin_out)|~$past(pin_oe)&$past(pin_in))) else $error("mix");
chk_out_wr: assert property (bus_wr&&bus_addr==8'h00|=>pin_out==$past(bus_wdata)) else $error("out");
chk_dir_wr: assert property (bus_wr&&bus_addr==8'h01|=>pin_oe==$past(bus_wdata)) else $error("oe");
chk_void_wr: assert property (bus_wr&&bus_addr>8'h02|=>$stable(pin_out)&&$stable(pin_oe)) else $error("void");
chk_rd_hold: assert property (!bus_rd|=>$stable(bus_rdata)) else $error("hold");
chk_pin_hold: assert property (!bus_wr|=>$stable(pin_out)&&$stable(pin_oe)) else $error("pin");
cover property (bus_wr&&bus_addr==8'h01);
cover property (bus_rd&&bus_addr==8'h00);
cover property (bus_wr&&bus_addr>8'h02);
cover property (timer_ovf);
endmodule // prb_chk
bind prb_port prb_chk u_chk(.core_clk(core_clk),.rstn(rstn),.bus_rd(bus_rd),.bus_wr(bus_wr),
 .bus_rvalid(bus_rvalid),.timer_ovf(timer_ovf),.bus_addr(bus_addr),.bus_wdata(bus_wdata),
 .bus_rdata(bus_rdata),.pin_in(pin_in),.pin_out(pin_out),.pin_oe(pin_oe));

/* File: dv/prb_cpu.sv */
/* cpu model: byte reads, writes, bit ops; assumes one bus */
`timescale 1ns/10ps
module prb_cpu(
 input  wire        core_clk,
 output logic       bus_rd,
 output logic       bus_wr,
 output logic [7:0] bus_addr,
 output logic [7:0] bus_wdata,
 input  wire  [7:0] bus_rdata
);
initial begin
 bus_rd=1'h0;
 bus_wr=1'h0;
 bus_addr=8'h00;
 bus_wdata=8'h00;
end
task xf(input w,input [7:0] a,d);
 @(posedge core_clk) {bus_addr,bus_wdata,bus_rd,bus_wr}<={a,d,!w,w};
 // released address shows garbage, not the last value
 @(posedge core_clk) {bus_addr,bus_rd,bus_wr}<={~a,2'b00};
endtask
task get(input [7:0] a,output [7:0] d);
 xf(0,a,0);
 @(posedge core_clk) d=bus_rdata;
endtask
task bop(input [7:0] a,input [2:0] n,input v);
 reg [7:0] d;
 get(a,d);
 d[n]=v;
 xf(1,a,d);
endtask
endmodule // prb_cpu

/* File: dv/test_port_rmw_bit_access.sv */
/* bench for prb_port; prb_cpu drives the bus */
`timescale 1ns/10ps
module test_port_rmw_bit_access;
logic core_clk=0,rstn=0;
wire bus_rd,bus_wr,bus_rvalid,timer_ovf;
wire [7:0] bus_addr,bus_wdata,bus_rdata,pin_out,pin_oe;
logic [7:0] pin_in=0,d,n,shadow_work_byte;
int n_fail=0,tests_run=0,cyc=0;
initial forever #12.5 core_clk=~core_clk;
prb_port #(.TICK_DIV(16'h0002)) DUT(.core_clk(core_clk),.rstn(rstn),.bus_addr(bus_addr),.bus_rd(bus_rd),
 .bus_wr(bus_wr),.bus_wdata(bus_wdata),.bus_rdata(bus_rdata),.bus_rvalid(bus_rvalid),.pin_in(pin_in),
 .pin_out(pin_out),.pin_oe(pin_oe),.timer_ovf(timer_ovf));
prb_cpu cpu(.core_clk(core_clk),.bus_rd(bus_rd),.bus_wr(bus_wr),.bus_addr(bus_addr),
 .bus_wdata(bus_wdata),.bus_rdata(bus_rdata));
task chk(input string s,input [7:0] e,g);
 tests_run++;
 if (g!==e) begin
  n_fail++;
  $display("MISMATCH %s exp %h got %h",s,e,g);
 end
endtask
task wrap_up;
 $display("%0d checks %0d fails",tests_run,n_fail);
 if (n_fail==0&&tests_run>0) $display("DONE - PASS");
 else $display("DONE - FAIL");
 $finish;
endtask
always @(posedge core_clk) if (++cyc==3000) begin n_fail++; wrap_up; end
task t_single_bit_set_op;
 cpu.xf(1,8'h01,8'h3F);
 cpu.xf(1,8'h00,8'h80);
 pin_in<=8'h40;
 cpu.get(8'h00,d);
 chk("rd",8'h40,d);
 cpu.bop(8'h00,0,1);
 cpu.get(8'h01,d);
 chk("out",8'h41,pin_out);
 chk("dir",8'hFF,d);
 $display("single_bit_set_op end");
endtask
task t_single_bit_clear_op;
 cpu.bop(8'h01,0,0);
 cpu.get(8'h00,d);
 chk("oe",8'hFE,pin_oe);
 chk("mix",8'h40,d);
 $display("single_bit_clear_op end");
endtask
task t_void;
 cpu.xf(1,8'hA5,8'hFF);
 @(posedge core_clk);
 chk("void",8'h41,pin_out);
 chk("void_oe",8'hFE,pin_oe);
 $display("void end");
endtask
task t_shadow;
 cpu.xf(1,8'h01,8'h3F);
 shadow_work_byte=8'h80;
 cpu.xf(1,8'h00,shadow_work_byte);
 shadow_work_byte[0]=1'b1;
 cpu.xf(1,8'h00,shadow_work_byte);
 @(posedge core_clk);
 chk("shadow",8'h81,pin_out);
 cpu.get(8'h00,d);
 chk("shadow_rd",8'h41,d);
 $display("shadow end");
endtask
task t_timer;
 cpu.xf(1,8'h02,8'hFE);
 cpu.get(8'h02,d);
 chk("cnt_lo",8'h00,d&8'h80);
 repeat(600) begin
  @(posedge core_clk);
  if (timer_ovf===1'b1) break;
 end
 n=0;
 do begin
  @(posedge core_clk);
  n++;
 end while (timer_ovf!==1'b1 && n<20);
 chk("ovf_gap",8'h04,n);
 cpu.get(8'h02,d);
 chk("cnt_hi",8'hFF,d|8'h01);
 $display("timer end");
endtask
initial begin
 repeat(12) @(posedge core_clk);
 rstn<=1;
 t_single_bit_set_op;
 t_single_bit_clear_op;
 t_void;
 t_shadow;
 t_timer;
 wrap_up;
end
endmodule // test_port_rmw_bit_access
